// file: core/spi_port_pkg.sv
// constants, types and helpers shared by the serial port unit
package spi_port_pkg;

   // register addresses on the special function register port
   localparam logic [7:0] ADDR_CFG = 8'ha1;
   localparam logic [7:0] ADDR_DIV = 8'ha2;
   localparam logic [7:0] ADDR_DAT = 8'ha3;
   localparam logic [7:0] ADDR_CTL = 8'hf8;

   // reset values
   localparam logic [7:0] CFG_RESET = 8'h07;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [7:0] DAT_RESET = 8'h00;
   localparam logic [7:0] CTL_RESET = 8'h06;

   // configuration register bit positions
   localparam int CFG_BUSY = 7;
   localparam int CFG_MASTER_ENABLE = 6;
   localparam int CFG_CPHA = 5;
   localparam int CFG_CPOL = 4;
   localparam int CFG_SEL = 3;
   localparam int CFG_RAW = 2;
   localparam int CFG_SHIFT_EMPTY_FLAG = 1;
   localparam int CFG_RXE = 0;

   // control register bit positions
   localparam int CTL_DONE = 7;
   localparam int CTL_WRITE_COLLISION_FLAG = 6;
   localparam int CTL_MODE_FAULT_FLAG = 5;
   localparam int CTL_OVR = 4;
   localparam int CTL_MODE_HI = 3;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_TXE = 1;
   localparam int CTL_EN = 0;

   // select line modes
   localparam logic [1:0] MODE_3WIRE = 2'h0;
   localparam logic [1:0] MODE_4WIRE_IN = 2'h1;

   // byte framing
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] LAST_HALF = 4'hf;

   // receive stream buffer shape
   localparam int RX_FIFO_WIDTH = 8;
   localparam int RX_FIFO_DEPTH = 16;

   // slave phase-1 hold after the last SCK edge
   localparam int T_SYSCLK_NS = 40;
   localparam int T_SLH_MIN_NS = 240;
   localparam int T_SLH_MAX_NS = 320;
   localparam int SLH_MIN_CYC = (T_SLH_MIN_NS + T_SYSCLK_NS - 1) / T_SYSCLK_NS;
   localparam int SLH_MAX_CYC = T_SLH_MAX_NS / T_SYSCLK_NS;
   localparam logic [3:0] SLH_WAIT = 4'((SLH_MIN_CYC + SLH_MAX_CYC) / 2);

   // master sequencer states
   typedef enum logic [0:0] {
      XFER_IDLE = 1'b0,
      XFER_RUN = 1'b1
   } xfer_state_e;

   // next value of a sticky flag: the hardware set wins over a write
   function automatic logic flag_next(input logic set, input logic wr,
                                      input logic wval, input logic q);
      flag_next = set | (wr ? wval : q);
   endfunction : flag_next

endpackage : spi_port_pkg

// file: core/stream_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // handshake terms
   assign in_ready_o = (count_q != (AW+1)'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_q[rd_ptr_q];

   // storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

endmodule : stream_fifo

// file: core/spi_master_slave_port.sv
// serial peripheral port: registers, master sequencer, slave engine
`timescale 1ns/100ps
module spi_master_slave_port (
   input wire logic CORE_CLK_I,
   input wire logic ARST_N_I,
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   input wire logic [7:0] SFR_WDATA_I,
   output logic [7:0] SFR_RDATA_O,
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE_O,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE_O,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE_O,
   input wire logic SEL_I,
   output logic SEL_O,
   output logic SEL_OE_O,
   output logic IRQ_O,
   output logic [7:0] RX_STREAM_DATA_O,
   output logic RX_STREAM_VALID_O,
   input wire logic RX_STREAM_READY_I
);

   // configuration state
   logic master_enable_q;
   logic cpha_q;
   logic cpol_q;
   logic [7:0] div_q;
   // control state
   logic done_q;
   logic write_collision_flag_q;
   logic mode_fault_flag_q;
   logic ovr_q;
   logic [1:0] mode_q;
   logic txe_q;
   logic en_q;
   // data path
   logic [7:0] txbuf_q;
   logic [7:0] rxbuf_q;
   logic rx_full_q;
   logic [7:0] sr_q;
   logic out_q;
   logic shift_empty_flag_q;
   logic [7:0] rdata_q;
   // master sequencer
   spi_port_pkg::xfer_state_e st_q;
   logic [3:0] half_q;
   logic [7:0] cnt_q;
   logic sck_q;
   // slave engine
   logic sck_prev_q;
   logic sel_a_q;
   logic sel_b_q;
   logic sel_filt_q;
   logic [3:0] bitcnt_q;
   logic [3:0] slh_q;

   // register port decode
   logic wr_cfg;
   logic wr_div;
   logic wr_dat;
   logic wr_ctl;
   logic rd_dat;
   assign wr_cfg = SFR_WR_I & (SFR_ADDR_I == spi_port_pkg::ADDR_CFG);
   assign wr_div = SFR_WR_I & (SFR_ADDR_I == spi_port_pkg::ADDR_DIV);
   assign wr_dat = SFR_WR_I & (SFR_ADDR_I == spi_port_pkg::ADDR_DAT);
   assign wr_ctl = SFR_WR_I & (SFR_ADDR_I == spi_port_pkg::ADDR_CTL);
   assign rd_dat = SFR_RD_I & (SFR_ADDR_I == spi_port_pkg::ADDR_DAT);

   // operating mode
   logic master_on;
   logic slave_on;
   logic four_wire;
   logic running;
   assign master_on = en_q & master_enable_q;
   assign slave_on = en_q & ~master_enable_q;
   assign four_wire = (mode_q == spi_port_pkg::MODE_4WIRE_IN);
   assign running = (st_q == spi_port_pkg::XFER_RUN);

   // select line de-glitch: level accepted after two equal samples
   logic sel_stable;
   logic sel_fall;
   assign sel_stable = (sel_a_q == sel_b_q);
   assign sel_fall = sel_stable & sel_filt_q & ~sel_b_q;

   // slave edge detection on the sampled SCK
   logic slave_sel;
   logic sck_tog;
   logic lead_edge;
   logic trail_edge;
   logic in_edge;
   logic out_edge;
   logic s_done;
   assign slave_sel = slave_on & (~four_wire | ~sel_filt_q);
   assign sck_tog = slave_sel & (SCK_I != sck_prev_q);
   assign lead_edge = sck_tog & (SCK_I != cpol_q);
   assign trail_edge = sck_tog & (SCK_I == cpol_q);
   // phase 0 samples the leading edge, phase 1 the trailing one
   assign in_edge = cpha_q ? trail_edge : lead_edge;
   assign out_edge = cpha_q ? lead_edge : trail_edge;
   assign s_done = in_edge & (bitcnt_q == spi_port_pkg::LAST_BIT);

   // master timing: each half period lasts divider plus one cycles
   logic fifo_ready;
   logic half_end;
   logic m_sample;
   logic m_done;
   logic m_start;
   assign half_end = running & (cnt_q == div_q);
   // last cycle of each bit period
   assign m_sample = half_end & half_q[0];
   assign m_done = m_sample & (half_q == spi_port_pkg::LAST_HALF);
   // a full stream buffer holds the next master transfer back
   assign m_start = ~running & master_on & ~txe_q & fifo_ready;

   // byte completion and capture
   logic xfer_done;
   logic in_bit;
   logic shift_now;
   logic [7:0] done_byte;
   logic overrun;
   logic rx_take;
   assign xfer_done = m_done | s_done;
   assign in_bit = master_enable_q ? MISO_I : MOSI_I;
   assign shift_now = m_sample | in_edge;
   assign done_byte = {sr_q[6:0], in_bit};
   assign overrun = s_done & rx_full_q;
   assign rx_take = xfer_done & ~overrun;

   // transmit buffer movement into the shift register
   logic load_idle;
   logic load_tx;
   logic collide;
   logic wr_take;
   assign load_idle = slave_on & ~txe_q & shift_empty_flag_q & ~sck_tog;
   assign load_tx = m_start | load_idle | (s_done & ~txe_q);
   assign collide = wr_dat & (~txe_q | running);

   // sck clears the shift-empty flag, except the edge that ends a byte and any out edge before the byte's first sample
   logic sr_tog;
   assign sr_tog = sck_tog & ~s_done & (in_edge | (bitcnt_q != 4'h0));
   assign wr_take = wr_dat & ~collide;

   // events and status
   logic mode_fault_flag_set;
   logic busy;
   logic [3:0] slh_next;
   assign mode_fault_flag_set = master_enable_q & four_wire & ~sel_filt_q;
   assign busy = running | (slave_on & (bitcnt_q != 4'h0));
   assign slh_next = slh_q + 4'h1;

   // read view of the two status registers
   logic [7:0] cfg_view;
   logic [7:0] ctl_view;
   assign cfg_view = {busy, master_enable_q, cpha_q, cpol_q,
                      ~sel_filt_q,
                      SEL_I,
                      master_enable_q | shift_empty_flag_q,
                      master_enable_q | ~rx_full_q};
   assign ctl_view = {done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q, mode_q, txe_q, en_q};

   // register writes and sticky flags
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         master_enable_q <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_MASTER_ENABLE];
         cpha_q <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_CPHA];
         cpol_q <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_CPOL];
         div_q <= spi_port_pkg::DIV_RESET;
         done_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_DONE];
         write_collision_flag_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_WRITE_COLLISION_FLAG];
         mode_fault_flag_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_MODE_FAULT_FLAG];
         ovr_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_OVR];
         mode_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_MODE_HI:
                                           spi_port_pkg::CTL_MODE_LO];
         en_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_EN];
      end else begin
         if (mode_fault_flag_set) begin
            master_enable_q <= 1'b0;
         end else if (wr_cfg) begin
            master_enable_q <= SFR_WDATA_I[spi_port_pkg::CFG_MASTER_ENABLE];
         end
         if (wr_cfg) begin
            cpha_q <= SFR_WDATA_I[spi_port_pkg::CFG_CPHA];
            cpol_q <= SFR_WDATA_I[spi_port_pkg::CFG_CPOL];
         end
         if (wr_div) begin
            div_q <= SFR_WDATA_I;
         end
         done_q <= spi_port_pkg::flag_next(xfer_done, wr_ctl,
            SFR_WDATA_I[spi_port_pkg::CTL_DONE], done_q);
         write_collision_flag_q <= spi_port_pkg::flag_next(collide, wr_ctl,
            SFR_WDATA_I[spi_port_pkg::CTL_WRITE_COLLISION_FLAG], write_collision_flag_q);
         mode_fault_flag_q <= spi_port_pkg::flag_next(mode_fault_flag_set, wr_ctl,
            SFR_WDATA_I[spi_port_pkg::CTL_MODE_FAULT_FLAG], mode_fault_flag_q);
         ovr_q <= spi_port_pkg::flag_next(overrun, wr_ctl,
            SFR_WDATA_I[spi_port_pkg::CTL_OVR], ovr_q);
         if (wr_ctl) begin
            mode_q <= SFR_WDATA_I[spi_port_pkg::CTL_MODE_HI:
                                  spi_port_pkg::CTL_MODE_LO];
         end
         if (mode_fault_flag_set) begin
            en_q <= 1'b0;
         end else if (wr_ctl) begin
            en_q <= SFR_WDATA_I[spi_port_pkg::CTL_EN];
         end
      end
   end

   // transmit and receive buffers
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         txbuf_q <= spi_port_pkg::DAT_RESET;
         txe_q <= spi_port_pkg::CTL_RESET[spi_port_pkg::CTL_TXE];
         rxbuf_q <= spi_port_pkg::DAT_RESET;
         rx_full_q <= ~spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_RXE];
      end else begin
         if (wr_take) begin
            txbuf_q <= SFR_WDATA_I;
            txe_q <= 1'b0;
         end else if (load_tx) begin
            txe_q <= 1'b1;
         end
         if (rx_take) begin
            rxbuf_q <= done_byte;
         end
         // a new byte wins over a read in the same cycle
         rx_full_q <= rx_take | (rx_full_q & ~rd_dat);
      end
   end

   // shift register, outgoing bit and shift-empty status
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sr_q <= spi_port_pkg::DAT_RESET;
         out_q <= 1'b0;
         shift_empty_flag_q <= spi_port_pkg::CFG_RESET[spi_port_pkg::CFG_SHIFT_EMPTY_FLAG];
      end else begin
         if (load_tx) begin
            sr_q <= txbuf_q;
         end else if (shift_now) begin
            sr_q <= done_byte;
         end
         if (m_start | load_idle) begin
            out_q <= txbuf_q[7];
         end else if (half_end & half_q[0] & ~m_done) begin
            out_q <= sr_q[6];
         end else if (s_done & ~cpha_q) begin
            out_q <= load_tx ? txbuf_q[7] : done_byte[7];
         end else if (out_edge) begin
            out_q <= sr_q[7];
         end else if (slh_q == spi_port_pkg::SLH_WAIT) begin
            out_q <= sr_q[7];
         end
         if (load_tx | sr_tog) begin
            shift_empty_flag_q <= 1'b0;
         end else if (xfer_done & txe_q) begin
            shift_empty_flag_q <= 1'b1;
         end
      end
   end

   // master sequencer: start, half periods and SCK level
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_q <= spi_port_pkg::XFER_IDLE;
         half_q <= 4'h0;
         cnt_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         case (st_q)
            spi_port_pkg::XFER_IDLE: begin
               half_q <= 4'h0;
               cnt_q <= 8'h00;
               sck_q <= cpol_q;
               if (m_start) begin
                  st_q <= spi_port_pkg::XFER_RUN;
                  sck_q <= cpol_q ^ cpha_q;
               end
            end
            spi_port_pkg::XFER_RUN: begin
               if (~master_on | m_done) begin
                  st_q <= spi_port_pkg::XFER_IDLE;
                  sck_q <= cpol_q;
               end else if (half_end) begin
                  half_q <= half_q + 4'h1;
                  cnt_q <= 8'h00;
                  sck_q <= cpol_q ^ cpha_q ^ ~half_q[0];
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            default: begin
               st_q <= spi_port_pkg::XFER_IDLE;
            end
         endcase
      end
   end

   // slave engine: select filter, bit counter, phase-1 hold timer
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sck_prev_q <= 1'b0;
         sel_a_q <= 1'b1;
         sel_b_q <= 1'b1;
         sel_filt_q <= 1'b1;
         bitcnt_q <= 4'h0;
         slh_q <= 4'h0;
      end else begin
         sck_prev_q <= SCK_I;
         sel_a_q <= SEL_I;
         sel_b_q <= sel_a_q;
         if (sel_stable) begin
            sel_filt_q <= sel_b_q;
         end
         if (~slave_on | (four_wire & sel_fall)) begin
            bitcnt_q <= 4'h0;
         end else if (s_done) begin
            bitcnt_q <= 4'h0;
         end else if (in_edge) begin
            bitcnt_q <= bitcnt_q + 4'h1;
         end
         if (s_done & cpha_q) begin
            slh_q <= 4'h1;
         end else if (~slave_on | (slh_q == spi_port_pkg::SLH_WAIT)) begin
            slh_q <= 4'h0;
         end else if (slh_q != 4'h0) begin
            slh_q <= slh_next;
         end
      end
   end

   // registered read data
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rdata_q <= 8'h00;
      end else if (SFR_RD_I) begin
         case (SFR_ADDR_I)
            spi_port_pkg::ADDR_CFG: rdata_q <= cfg_view;
            spi_port_pkg::ADDR_DIV: rdata_q <= div_q;
            spi_port_pkg::ADDR_DAT: rdata_q <= rxbuf_q;
            spi_port_pkg::ADDR_CTL: rdata_q <= ctl_view;
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // copy of each received byte that causes no overrun to the stream buffer while it has room
   stream_fifo #(
      .WIDTH(spi_port_pkg::RX_FIFO_WIDTH),
      .DEPTH(spi_port_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i(CORE_CLK_I),
      .arst_n_i(ARST_N_I),
      .in_valid_i(rx_take),
      .in_ready_o(fifo_ready),
      .in_data_i(done_byte),
      .out_valid_o(RX_STREAM_VALID_O),
      .out_ready_i(RX_STREAM_READY_I),
      .out_data_o(RX_STREAM_DATA_O)
   );

   // pins and outputs
   assign SFR_RDATA_O = rdata_q;
   assign SCK_O = sck_q;
   assign SCK_OE_O = master_on;
   assign MOSI_O = out_q;
   assign MOSI_OE_O = master_on;
   assign MISO_O = out_q;
   assign MISO_OE_O = slave_sel;
   assign SEL_O = mode_q[0];
   assign SEL_OE_O = en_q & mode_q[1];
   // port interrupt request from the four event flags
   assign IRQ_O = done_q | write_collision_flag_q | mode_fault_flag_q | ovr_q;

endmodule : spi_master_slave_port

// file: verification/spi_port_properties.sv
// port checker for the serial port unit
`timescale 1ns/100ps
module spi_port_checker (
   input wire logic CORE_CLK_I,
   input wire logic ARST_N_I,
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   input wire logic [7:0] SFR_RDATA_O,
   input wire logic SEL_I,
   input wire logic SCK_O,
   input wire logic SCK_OE_O,
   input wire logic MOSI_OE_O,
   input wire logic MISO_OE_O,
   input wire logic IRQ_O,
   input wire logic [7:0] RX_STREAM_DATA_O,
   input wire logic RX_STREAM_VALID_O,
   input wire logic RX_STREAM_READY_I
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // an address outside the four registers
   wire odd = !(SFR_ADDR_I inside {8'ha1, 8'ha2, 8'ha3, 8'hf8});
   // link enables, read port and flag relations
   a_oe_exclusive: assert property (!(SCK_OE_O && MISO_OE_O))
      else $error("both drivers on");
   a_mosi_oe_pair: assert property (MOSI_OE_O == SCK_OE_O)
      else $error("master enables differ");
   a_rdata_hold: assert property (!SFR_RD_I |=> $stable(SFR_RDATA_O))
      else $error("read data moved");
   a_unmapped_zero: assert property (
      SFR_RD_I && odd |=> SFR_RDATA_O == 8'h00) else $error("unmapped read");
   a_raw_select: assert property (
      SFR_RD_I && SFR_ADDR_I == 8'ha1 |=> SFR_RDATA_O[2] == $past(SEL_I))
      else $error("raw select bit wrong");
   a_stream_hold: assert property (
      RX_STREAM_VALID_O && !RX_STREAM_READY_I |=>
      RX_STREAM_VALID_O && $stable(RX_STREAM_DATA_O)) else $error("stream lost");
   a_irq_sw_clear: assert property (
      $fell(IRQ_O) |-> $past(SFR_WR_I) && $past(SFR_ADDR_I) == 8'hf8)
      else $error("flag cleared by hardware");
   a_oe_by_write: assert property ($rose(SCK_OE_O) |-> $past(SFR_WR_I))
      else $error("master enable without write");
   c_sck_move: cover property (SCK_OE_O && $changed(SCK_O));
   c_stream_pop: cover property (RX_STREAM_VALID_O && RX_STREAM_READY_I);
   c_irq_up: cover property ($rose(IRQ_O));
endmodule : spi_port_checker
bind spi_master_slave_port spi_port_checker chk_i (
   .CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .SFR_ADDR_I(SFR_ADDR_I),
   .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O),
   .SEL_I(SEL_I), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .MOSI_OE_O(MOSI_OE_O),
   .MISO_OE_O(MISO_OE_O), .IRQ_O(IRQ_O), .RX_STREAM_DATA_O(RX_STREAM_DATA_O),
   .RX_STREAM_VALID_O(RX_STREAM_VALID_O),
   .RX_STREAM_READY_I(RX_STREAM_READY_I));

// file: verification/spi_far_slave.sv
// far-end serial slave clocked by the port's sck output
`timescale 1ns/100ps
module spi_far_slave (
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic pol_i,
   input wire logic pha_i,
   input wire logic load_i,
   input wire logic [7:0] tx_i,
   output logic miso_o,
   output logic [7:0] sr_o
);
   // preset byte; phase 1 shows a wrong bit until the first edge
   always @(posedge load_i) begin
      sr_o = tx_i;
      miso_o = pha_i ? ~tx_i[7] : tx_i[7];
   end
   // sample on the data edge, shift out on the other, msb first
   always @(sck_i) begin
      if ((sck_i != pol_i) ^ pha_i)
         sr_o = {sr_o[6:0], mosi_i};
      else
         miso_o = sr_o[7];
   end
endmodule : spi_far_slave

// file: verification/spi_master_slave_port_test.sv
// self-checking bench of the serial port unit
`timescale 1ns/100ps
module spi_master_slave_port_test;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, load = 1'b0;
   logic sck_in = 1'b0, mosi_in = 1'b0, sel_in = 1'b1, ready = 1'b0;
   logic pol = 1'b0, pha = 1'b0, last = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, far_tx = 8'h00;
   logic sck, mosi, miso, miso_s, miso_oe, sel_o, sel_oe, irq, s_valid;
   logic [7:0] rdata, s_data, far_rx, v, d, f, s, dv;
   logic [7:0] q [$];
   logic [7:0] ra [5] = '{8'ha1, 8'ha2, 8'ha3, 8'hf8, 8'h10};
   logic [7:0] re [5] = '{8'h07, 8'h00, 8'h00, 8'h06, 8'h00};
   int error_cnt = 0, total_checks = 0, cyc = 0, edges = 0, run = 0;
   int hmin = 0, n = 0;
   always #20 clk = ~clk;
   spi_master_slave_port uut (
      .CORE_CLK_I(clk), .ARST_N_I(rst_n), .SFR_ADDR_I(addr),
      .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
      .SFR_RDATA_O(rdata), .SCK_I(sck_in), .SCK_O(sck), .SCK_OE_O(),
      .MOSI_I(mosi_in), .MOSI_O(mosi), .MOSI_OE_O(), .MISO_I(miso),
      .MISO_O(miso_s), .MISO_OE_O(miso_oe), .SEL_I(sel_in), .SEL_O(sel_o),
      .SEL_OE_O(sel_oe), .IRQ_O(irq), .RX_STREAM_DATA_O(s_data),
      .RX_STREAM_VALID_O(s_valid), .RX_STREAM_READY_I(ready));
   spi_far_slave far (.sck_i(sck), .mosi_i(mosi), .pol_i(pol), .pha_i(pha),
      .load_i(load), .tx_i(far_tx), .miso_o(miso), .sr_o(far_rx));
   // control word after a master byte, with or without a collision
   function automatic logic [7:0] done_ctl(input logic write_collision_flag);
      return {1'b1, write_collision_flag, 4'h0, 2'h3};
   endfunction : done_ctl
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [7:0] dat);
      @(negedge clk);
      addr = a;
      wdata = dat;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [7:0] dat);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      dat = rdata;
   endtask : rreg
   // far master: select, eight bits at the given phase, deselect
   task automatic sbyte(input logic [7:0] m, input logic ph,
                        output logic [7:0] o);
      @(negedge clk);
      sel_in = 1'b0;
      repeat (4) @(negedge clk);
      chk({7'h0, miso_oe}, 8'h01);
      for (int b = 7; b >= 0; b--) begin
         if (!ph)
            mosi_in = m[b];
         repeat (6) @(negedge clk);
         if (!ph)
            o[b] = miso_s;
         sck_in = 1'b1;
         if (ph)
            mosi_in = m[b];
         repeat (6) @(negedge clk);
         if (ph)
            o[b] = miso_s;
         sck_in = 1'b0;
      end
      repeat (6) @(negedge clk);
      sel_in = 1'b1;
      repeat (4) @(negedge clk);
   endtask : sbyte
   task automatic results;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   // timeout, sck edge count and shortest sck half
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         results();
      end
      if (sck !== last) begin
         // the run before the first edge is idle time, not a half period
         if (edges > 0)
            hmin = (run < hmin) ? run : hmin;
         edges++;
         run = 1;
      end else
         run++;
      last = sck;
   end
   initial begin
      n = $urandom(32'he4cd4e43);
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 5; i++) begin
         rreg(ra[i], v);
         chk(v, re[i]);
      end
      for (int m = 0; m < 4; m++) begin
         wreg(8'hf8, {4'h0, 2'(m), 2'h1});
         chk({6'h0, sel_oe, sel_o}, 8'(m));
      end
      // master bytes in all phases and polarities, stream stalled
      for (int i = 0; i < 16; i++) begin
         {pha, pol} = 2'(i);
         dv = (i == 15) ? 8'hff : 8'($urandom_range(3, 0));
         d = 8'($urandom);
         far_tx = 8'($urandom);
         wreg(8'ha1, {2'h1, pha, pol, 4'h0});
         wreg(8'ha2, dv);
         wreg(8'hf8, 8'h01);
         load = 1'b1;
         @(negedge clk);
         load = 1'b0;
         hmin = 9999;
         edges = 0;
         wreg(8'ha3, d);
         rreg(8'ha1, v);
         chk(v & 8'h80, 8'h80);
         wreg(8'ha3, 8'h5a);
         n = 0;
         v = 8'h00;
         while (v[7] !== 1'b1 && n < 9000) begin
            rreg(8'hf8, v);
            n++;
         end
         chk(v, done_ctl(1'b1));
         chk(far_rx, d);
         rreg(8'ha3, v);
         chk(v, far_tx);
         chk({7'h0, sck}, {7'h0, pol});
         chk(8'(edges), 8'h10);
         chk(8'(hmin - 1), dv);
         wreg(8'hf8, 8'h01);
         q.push_back(far_tx);
      end
      foreach (q[k]) begin
         chk({7'h0, s_valid}, 8'h01);
         chk(s_data, q[k]);
         ready = 1'b1;
         @(negedge clk);
         ready = 1'b0;
      end
      chk({7'h0, s_valid}, 8'h00);
      ready = 1'b1;
      // another master pulls select low in multi-master mode
      wreg(8'ha1, 8'h40);
      wreg(8'hf8, 8'h05);
      sel_in = 1'b0;
      repeat (6) @(negedge clk);
      sel_in = 1'b1;
      rreg(8'hf8, v);
      chk(v, 8'h26);
      rreg(8'ha1, v);
      chk(v & 8'h40, 8'h00);
      chk({7'h0, irq}, 8'h01);
      wreg(8'hf8, 8'h04);
      chk({7'h0, irq}, 8'h00);
      // slave byte with preload, then an overrun
      wreg(8'ha1, 8'h00);
      wreg(8'hf8, 8'h05);
      d = 8'($urandom);
      wreg(8'ha3, d);
      f = 8'($urandom);
      sbyte(f, 1'b0, s);
      chk(s, d);
      rreg(8'ha1, v);
      chk(v & 8'h01, 8'h00);
      rreg(8'hf8, v);
      chk(v & 8'h80, 8'h80);
      wreg(8'hf8, 8'h05);
      sbyte(8'ha5, 1'b0, s);
      rreg(8'hf8, v);
      chk(v & 8'h10, 8'h10);
      rreg(8'ha3, v);
      chk(v, f);
      rreg(8'ha1, v);
      chk(v & 8'h01, 8'h01);
      // slave byte at phase 1 after a drained shift register
      wreg(8'ha1, 8'h20);
      d = 8'($urandom);
      wreg(8'ha3, d);
      f = 8'($urandom);
      sbyte(f, 1'b1, s);
      chk(s, d);
      rreg(8'ha3, v);
      chk(v, f);
      results();
   end
endmodule : spi_master_slave_port_test
